// File: gpt_timers.sv
// general purpose timers: one stand-alone 16-bit timer and four joinable pairs
// assumes one 100 MHz clock, a classic wishbone master and async external pins
// What this block does
// - stand-alone timer: 16-bit, internal timer, synchronous or asynchronous pin counter
// - stand-alone flags on period match or on gate falling edge
// - control bit 15 written 1 starts, written 0 stops the stand-alone timer
// - halt-in-idle bit set stops a timer while the device is idle
// - gate enable acts only with internal clock; counts while gate is high
// - prescale bits 5-4: 11=1:256, 10=1:64, 01=1:8, 00=1:1
// - sync bit picks synchronized or asynchronous pin counting, internal clock ignores it
// - clock source bit: 1 counts pin rising edges, 0 the instruction clock
// - unimplemented control bits read zero and ignore writes
// - split pair timers are synchronous only, no asynchronous counter
// - even control bit 3 joins the pair into one 32-bit timer
// - joined pair: even count is low word, odd count high word
// - joined pair: odd control ignored, even control and pin drive all
// - joined pair signals its match through the odd timer flag
// - joined period is odd period high word with even period low word
// - only timers two and three provide the capture/compare time base
// - pair two/three triggers converter one, pair four/five converter two
// - only timers two and three raise dma requests
// - odd control holds run, idle, gate, prescale, source but no join bit
//
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "gpt_defines.svh"

module gpt_timers (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire gpt_pkg::gpt_wbreq_t wbReq,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic idleMode,
  input wire logic [8:0] timerPin,
  output logic [8:0] timerEvent,
  output gpt_pkg::gpt_trig_t trigOut,
  output logic [15:0] captureBaseLow,
  output logic [15:0] captureBaseHigh
);
  import gpt_pkg::*;

  localparam int NT = `GPT_NUM_TIMERS;

  // index 0 is the stand-alone timer, 1..8 are timers two..nine
  function automatic logic [15:0] ctrlMask(input int t);
    if (t == 0) begin
      ctrlMask = `GPT_MASK_STANDALONE;
    end else if (t % 2 == 1) begin
      ctrlMask = `GPT_MASK_EVEN;
    end else begin
      ctrlMask = `GPT_MASK_ODD;
    end
  endfunction

  function automatic logic [7:0] pscLimit(input logic [1:0] sel);
    unique case (sel)
      2'h3: pscLimit = `GPT_PSC_LIM_256;
      2'h2: pscLimit = `GPT_PSC_LIM_64;
      2'h1: pscLimit = `GPT_PSC_LIM_8;
      2'h0: pscLimit = `GPT_PSC_LIM_1;
    endcase
  endfunction

  logic [15:0] ctrl_ff [NT];
  logic [15:0] nxt_ctrl [NT];
  logic [15:0] count_ff [NT];
  logic [15:0] nxt_count [NT];
  logic [15:0] period_ff [NT];
  logic [15:0] nxt_period [NT];
  logic [7:0] psc_ff [NT];
  logic [7:0] nxt_psc [NT];
  logic [8:0] flag_ff, nxt_flag;
  logic [8:0] evt_ff, nxt_evt;
  logic [8:0] pinS1_ff, pinS2_ff, pinS3_ff, pinLevel_ff, nxt_pinLevel;
  logic [31:0] dat_ff, nxt_dat;
  logic ack_ff, nxt_ack;
  logic [1:0] adc_ff, nxt_adc, dma_ff, nxt_dma;
  logic [15:0] capLo_ff, capHi_ff;

  logic [15:0] effCtrl [NT];
  logic [8:0] run, rawEdge, tick, gateFall, pinRise, pinFall, pinAsyncRise;
  logic [8:0] ctrlWr, countWr, periodWr;
  logic [3:0] joined;
  logic busWr, flagWr;
  logic [3:0] selT;
  logic [1:0] selR;
  logic [15:0] wrData, wrLane;

  // pin synchronisers; only the second stage reads the first
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinS1_ff <= 9'h000;
      pinS2_ff <= 9'h000;
      pinS3_ff <= 9'h000;
      pinLevel_ff <= 9'h000;
    end else begin
      pinS1_ff <= timerPin;
      pinS2_ff <= pinS1_ff;
      pinS3_ff <= pinS2_ff;
      pinLevel_ff <= nxt_pinLevel;
    end
  end

  always_comb begin
    // a change only counts once stages two and three agree
    nxt_pinLevel = pinLevel_ff;
    for (int i = 0; i < NT; i++) begin
      if (pinS2_ff[i] == pinS3_ff[i]) begin
        nxt_pinLevel[i] = pinS2_ff[i];
      end
    end
  end

  assign pinRise = nxt_pinLevel & ~pinLevel_ff;
  assign pinFall = ~nxt_pinLevel & pinLevel_ff;
  // unfiltered edge, one cycle sooner; the closest an all-synchronous design gets to async
  assign pinAsyncRise = pinS2_ff & ~pinS3_ff;

  // bus decode
  assign selT = wbReq.adr[7:4];
  assign selR = wbReq.adr[3:2];
  assign busWr = wbReq.cyc && wbReq.stb && wbReq.we && ack_ff;
  assign flagWr = busWr && (wbReq.adr == `GPT_ADR_FLAGS);
  assign wrLane = {{8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};

  genvar g;
  generate
    for (g = 0; g < NT; g++) begin : gTimer
      logic hit;
      logic [15:0] ownCtrl;
      assign hit = busWr && (selT == 4'(g)) && (wbReq.adr[1:0] == 2'h0);
      assign ctrlWr[g] = hit && (selR == `GPT_OFF_CTRL);
      assign countWr[g] = hit && (selR == `GPT_OFF_COUNT);
      assign periodWr[g] = hit && (selR == `GPT_OFF_PERIOD);
      assign ownCtrl = ctrl_ff[g];
      if (g > 0 && g % 2 == 0) begin : gOdd
        // joined pair: the odd timer runs on the even timer's setup
        assign effCtrl[g] = joined[(g - 2) / 2] ? ctrl_ff[g - 1] : ownCtrl;
      end else begin : gOwn
        assign effCtrl[g] = ownCtrl;
      end
      assign run[g] = effCtrl[g][`GPT_BIT_RUN] &&
        !(effCtrl[g][`GPT_BIT_HALT_IDLE] && idleMode);
      always_comb begin
        if (effCtrl[g][`GPT_BIT_CLKSRC]) begin
          // pair timers always use the filtered edge
          if (g == 0 && !effCtrl[g][`GPT_BIT_SYNC]) begin
            rawEdge[g] = pinAsyncRise[g];
          end else begin
            rawEdge[g] = pinRise[g];
          end
          gateFall[g] = 1'b0;
        end else begin
          rawEdge[g] = !effCtrl[g][`GPT_BIT_GATE] || pinLevel_ff[g];
          gateFall[g] = effCtrl[g][`GPT_BIT_GATE] && pinFall[g] && run[g];
        end
        nxt_psc[g] = psc_ff[g];
        tick[g] = 1'b0;
        if (!run[g] || ctrlWr[g]) begin
          nxt_psc[g] = 8'h00;
        end else if (rawEdge[g]) begin
          if (psc_ff[g] >= pscLimit(effCtrl[g][`GPT_BIT_PSC_HI:`GPT_BIT_PSC_LO])) begin
            nxt_psc[g] = 8'h00;
            tick[g] = 1'b1;
          end else begin
            nxt_psc[g] = psc_ff[g] + 8'h01;
          end
        end
        nxt_ctrl[g] = ctrl_ff[g];
        if (ctrlWr[g]) begin
          nxt_ctrl[g] = ((ctrl_ff[g] & ~wrLane) | (wbReq.dat[15:0] & wrLane)) &
            ctrlMask(g);
        end
        nxt_period[g] = period_ff[g];
        if (periodWr[g]) begin
          nxt_period[g] = (period_ff[g] & ~wrLane) | (wbReq.dat[15:0] & wrLane);
        end
      end
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          ctrl_ff[g] <= `GPT_RST_CTRL;
          period_ff[g] <= `GPT_RST_PERIOD;
          count_ff[g] <= `GPT_RST_COUNT;
          psc_ff[g] <= 8'h00;
        end else begin
          ctrl_ff[g] <= nxt_ctrl[g];
          period_ff[g] <= nxt_period[g];
          count_ff[g] <= nxt_count[g];
          psc_ff[g] <= nxt_psc[g];
        end
      end
    end
    for (g = 0; g < `GPT_NUM_PAIRS; g++) begin : gPair
      assign joined[g] = ctrl_ff[2 * g + 1][`GPT_BIT_JOIN];
    end
  endgenerate

  // counting and match events
  always_comb begin
    logic [31:0] full;
    logic [31:0] per32;
    int e;
    int o;
    full = 32'h0;
    per32 = 32'h0;
    e = 0;
    o = 0;
    nxt_evt = gateFall;
    for (int t = 0; t < NT; t++) begin
      nxt_count[t] = count_ff[t];
      if (tick[t]) begin
        if (count_ff[t] == period_ff[t]) begin
          nxt_count[t] = 16'h0000;
          nxt_evt[t] = 1'b1;
        end else begin
          nxt_count[t] = count_ff[t] + 16'h0001;
        end
      end
    end
    for (int p = 0; p < `GPT_NUM_PAIRS; p++) begin
      e = 2 * p + 1;
      o = 2 * p + 2;
      if (joined[p]) begin
        full = {count_ff[o], count_ff[e]};
        per32 = {period_ff[o], period_ff[e]};
        nxt_count[e] = count_ff[e];
        nxt_count[o] = count_ff[o];
        nxt_evt[e] = 1'b0;
        nxt_evt[o] = gateFall[e];
        if (tick[e]) begin
          if (full == per32) begin
            nxt_count[e] = 16'h0000;
            nxt_count[o] = 16'h0000;
            nxt_evt[o] = 1'b1;
          end else begin
            full = full + 32'h0000_0001;
            nxt_count[e] = full[15:0];
            nxt_count[o] = full[31:16];
          end
        end
      end
    end
    for (int t = 0; t < NT; t++) begin
      if (countWr[t]) begin
        nxt_count[t] = (count_ff[t] & ~wrLane) | (wbReq.dat[15:0] & wrLane);
      end
    end
    // write-one-to-clear, but a new event wins over the clear
    nxt_flag = flag_ff;
    if (flagWr && wbReq.sel[0]) begin
      nxt_flag[7:0] = flag_ff[7:0] & ~wbReq.dat[7:0];
    end
    if (flagWr && wbReq.sel[1]) begin
      nxt_flag[8] = flag_ff[8] & ~wbReq.dat[8];
    end
    nxt_flag = nxt_flag | nxt_evt;
    nxt_adc = {nxt_evt[4], nxt_evt[2]};
    nxt_dma = {nxt_evt[2], nxt_evt[1]};
  end

  // bus answer: ack one cycle after the request, write lands on the ack edge
  always_comb begin
    nxt_ack = wbReq.cyc && wbReq.stb && !ack_ff;
    nxt_dat = 32'h0000_0000;
    if (wbReq.adr == `GPT_ADR_FLAGS) begin
      nxt_dat = {23'h0, flag_ff};
    end else if (selT < 4'(NT) && wbReq.adr[1:0] == 2'h0) begin
      unique case (selR)
        `GPT_OFF_COUNT: nxt_dat = {16'h0, count_ff[selT]};
        `GPT_OFF_PERIOD: nxt_dat = {16'h0, period_ff[selT]};
        `GPT_OFF_CTRL: nxt_dat = {16'h0, ctrl_ff[selT]};
        default: nxt_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
      flag_ff <= 9'h000;
      evt_ff <= 9'h000;
      adc_ff <= 2'h0;
      dma_ff <= 2'h0;
      capLo_ff <= 16'h0000;
      capHi_ff <= 16'h0000;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      flag_ff <= nxt_flag;
      evt_ff <= nxt_evt;
      adc_ff <= nxt_adc;
      dma_ff <= nxt_dma;
      capLo_ff <= nxt_count[1];
      capHi_ff <= nxt_count[2];
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = dat_ff;
  assign timerEvent = evt_ff;
  assign trigOut.adcTrigger = adc_ff;
  assign trigOut.dmaRequest = dma_ff;
  assign captureBaseLow = capLo_ff;
  assign captureBaseHigh = capHi_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence sMatch32;
    joined[0] && tick[1] && ({count_ff[2], count_ff[1]} == {period_ff[2], period_ff[1]})
      && !countWr[1] && !countWr[2];
  endsequence

  sequence sPairCleared;
    count_ff[1] == 16'h0000 && count_ff[2] == 16'h0000 && evt_ff[2];
  endsequence

  ack_single_a: assert property (ack_ff |=> !ack_ff)
    else $error("ack stood longer than one cycle");
  stop_holds_a: assert property (!run[0] && !countWr[0] |=> $stable(count_ff[0]))
    else $error("stopped timer changed its count");
  reserved_zero_a: assert property ((ctrl_ff[0] & ~`GPT_MASK_STANDALONE) == 16'h0)
    else $error("unimplemented control bit set");
  // idle halt and 1:8 are watched on timer index 5, where both modes get exercised
  idle_halt_a: assert property (idleMode && ctrl_ff[5][`GPT_BIT_HALT_IDLE] |-> !tick[5])
    else $error("timer ticked in idle with halt bit set");
  // a switch to 1:1 may tick sooner, so only a held 1:8 or slower ratio is judged
  psc_eight_a: assert property (tick[5] && ctrl_ff[5][5:4] == 2'h1
    |=> (!tick[5] || ctrl_ff[5][5:4] == 2'h0) [*7])
    else $error("1:8 prescale ticked early");
  wrap_flag_a: assert property (tick[0] && count_ff[0] == period_ff[0] && !countWr[0]
    |=> count_ff[0] == 16'h0 && flag_ff[0] && evt_ff[0])
    else $error("period match did not wrap and flag");
  joined_even_a: assert property (joined[0] && !gateFall[1] |=> !evt_ff[1])
    else $error("joined pair flagged through the even timer");
  match32_a: assert property (sMatch32 |=> sPairCleared)
    else $error("32-bit period match missed");
  // with the pin clock selected only a period match may raise an event, never the gate
  gate_ext_a: assert property (ctrl_ff[0][`GPT_BIT_CLKSRC]
    && !(tick[0] && count_ff[0] == period_ff[0]) |=> !evt_ff[0])
    else $error("gate acted with external clock");
  dma_pair_a: assert property (evt_ff[1] |-> dma_ff[0])
    else $error("timer two event gave no dma request");

  adc_pair_a: assert property (evt_ff[2] |-> adc_ff[0] && dma_ff[1])
    else $error("pair two/three event gave no trigger");
  cap_base_a: assert property (capLo_ff == count_ff[1] && capHi_ff == count_ff[2])
    else $error("capture time base lags the count");
  reserved_pair_a: assert property ((ctrl_ff[1] & ~`GPT_MASK_EVEN) == 16'h0
    && (ctrl_ff[2] & ~`GPT_MASK_ODD) == 16'h0)
    else $error("unimplemented pair control bit set");
  // a stopped pair must freeze its high word too, not only the word that ticks
  pair_stop_a: assert property (joined[0] && !run[1] && !countWr[1] && !countWr[2]
    |=> $stable(count_ff[2]))
    else $error("stopped pair changed its high word");
  // split pair timers never take the unfiltered edge, so each tick waits for a settled level
  split_sync_a: assert property (!joined[1] && ctrl_ff[4][`GPT_BIT_CLKSRC] && run[4]
    && ctrl_ff[4][5:4] == 2'h0 && !ctrlWr[4] |-> tick[4] == pinRise[4])
    else $error("split pair timer counted an unfiltered edge");
  // the asynchronous path takes the first synchronised edge without waiting for agreement
  async_edge_a: assert property (run[0] && !ctrlWr[0] && ctrl_ff[0][5:4] == 2'h0
    && ctrl_ff[0][`GPT_BIT_CLKSRC] && !ctrl_ff[0][`GPT_BIT_SYNC]
    |-> tick[0] == pinAsyncRise[0])
    else $error("asynchronous pin edge not counted");
  // a new event in the clear cycle must survive, or software would lose it
  flag_set_wins_a: assert property (nxt_evt[0] |=> flag_ff[0])
    else $error("event lost against a flag clear");
  flag_clear_a: assert property (flagWr && wbReq.sel[0] && wbReq.dat[0]
    && !nxt_evt[0] |=> !flag_ff[0])
    else $error("flag clear ignored");

endmodule // gpt_timers
`default_nettype wire

// File: gpt_defines.svh
// offsets, field positions, write masks and reset values of the timer block
// assumes a 32-bit wishbone register bus with byte addresses on adr_i[7:0]
`ifndef GPT_DEFINES_SVH
`define GPT_DEFINES_SVH

`define GPT_NUM_TIMERS 9
`define GPT_NUM_PAIRS 4
`define GPT_ADR_W 8
`define GPT_TIMER_STRIDE 8'h10
`define GPT_OFF_COUNT 2'h0
`define GPT_OFF_PERIOD 2'h1
`define GPT_OFF_CTRL 2'h2
`define GPT_ADR_FLAGS 8'h90

`define GPT_BIT_RUN 15
`define GPT_BIT_HALT_IDLE 13
`define GPT_BIT_GATE 6
`define GPT_BIT_PSC_HI 5
`define GPT_BIT_PSC_LO 4
`define GPT_BIT_JOIN 3
`define GPT_BIT_SYNC 2
`define GPT_BIT_CLKSRC 1

`define GPT_MASK_STANDALONE 16'hA076
`define GPT_MASK_EVEN 16'hA07A
`define GPT_MASK_ODD 16'hA072

`define GPT_RST_CTRL 16'h0000
`define GPT_RST_COUNT 16'h0000
`define GPT_RST_PERIOD 16'h0000

`define GPT_PSC_LIM_1 8'h00
`define GPT_PSC_LIM_8 8'h07
`define GPT_PSC_LIM_64 8'h3F
`define GPT_PSC_LIM_256 8'hFF

`endif

// File: gpt_pkg.sv
// types shared by the timer block
// assumes gpt_defines.svh is on the include path
package gpt_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } gpt_wbreq_t;

  typedef struct packed {
    logic [1:0] adcTrigger;
    logic [1:0] dmaRequest;
  } gpt_trig_t;
endpackage

// File: gpt_pin_model.sv
// pin model: drives the external clock and gate pins of the timer block
// assumes the bench calls its tasks just after a rising sys_clk edge
`timescale 1ns/1ps
`default_nettype none
module gpt_pin_model (
  input wire logic sys_clk,
  output logic [8:0] timerPin
);
  // pins idle low; a pin clock stands still between bursts
  initial timerPin = 9'h000;
  task automatic burst(input int idx, input int n, input int half);
    repeat (n) begin
      timerPin[idx] <= 1'h1; // only rising edges should count
      repeat (half) @(posedge sys_clk);
      timerPin[idx] <= 1'h0;
      repeat (half) @(posedge sys_clk);
    end
  endtask
  task automatic level(input int idx, input logic v);
    timerPin[idx] <= v; // gate level held until changed
    @(posedge sys_clk);
  endtask
endmodule // gpt_pin_model
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the timer block: bus tasks, pin model, event counters
// assumes gpt_pkg, gpt_timers and gpt_pin_model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gpt_pkg::*;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  gpt_wbreq_t wbReq = '0;
  logic idleMode = 1'h0;
  logic [31:0] dat_o;
  logic [31:0] rdat;
  logic ack_o;
  logic [8:0] timerPin;
  logic [8:0] timerEvent;
  gpt_trig_t trigOut;
  logic [15:0] capLow;
  logic [15:0] capHigh;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  int evCnt[9];
  int adcCnt[2];
  int dmaCnt[2];
  int b[4];
  int g;
  int p;
  int divTab[4] = '{1, 8, 64, 256};
  logic [15:0] maskTab[3] = '{16'hA076, 16'hA07A, 16'hA072};
  logic [15:0] v1;
  logic [15:0] v2;
  gpt_timers i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .wbReq(wbReq), .dat_o(dat_o),
    .ack_o(ack_o), .idleMode(idleMode), .timerPin(timerPin), .timerEvent(timerEvent),
    .trigOut(trigOut), .captureBaseLow(capLow), .captureBaseHigh(capHigh));
  gpt_pin_model i_pins (.sys_clk(sys_clk), .timerPin(timerPin));
  always #5 sys_clk = ~sys_clk;
  // event pulses stand one cycle, so they are tallied at every edge
  always @(posedge sys_clk) begin
    cycles++;
    for (int i = 0; i < 9; i++) evCnt[i] += int'(timerEvent[i] === 1'h1);
    for (int i = 0; i < 2; i++) begin
      adcCnt[i] += int'(trigOut.adcTrigger[i] === 1'h1);
      dmaCnt[i] += int'(trigOut.dmaRequest[i] === 1'h1);
    end
    if (cycles == 40000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // classic single cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    wbReq <= '{1'h1, 1'h1, w, a, 4'h3, {16'h0000, d}};
    do begin
      @(posedge sys_clk);
    end while (ack_o !== 1'h1);
    rdat = dat_o;
    wbReq <= '0;
  endtask
  function automatic logic [7:0] ra(input int t, input int o);
    return 8'(t * 16 + o * 4);
  endfunction
  task automatic gap(input int bit_i, output int n);
    n = 0;
    while (timerEvent[bit_i] !== 1'h1 && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (timerEvent[bit_i] !== 1'h1 && n < 5000);
  endtask
  task automatic snap();
    b = '{evCnt[1], evCnt[2], adcCnt[0], dmaCnt[1]};
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(66));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'h1;
    for (int t = 0; t < 9; t++) begin
      wb(1'h0, ra(t, 2), 16'h0000);
      check(rdat, 32'h0000_0000);
    end
    wb(1'h0, 8'hA0, 16'h0000);
    check(rdat, 32'h0000_0000);
    for (int t = 0; t < 3; t++) begin
      wb(1'h1, ra(t, 2), 16'hFFFF);
      wb(1'h0, ra(t, 2), 16'h0000);
      check(rdat, {16'h0000, maskTab[t]});
      wb(1'h1, ra(t, 2), 16'h0000);
    end
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      p = $urandom_range(5, 1);
      // stop first: a count above a smaller new period would run the whole 16-bit range
      wb(1'h1, ra(5, 2), 16'h0000);
      wb(1'h1, ra(5, 0), 16'h0000);
      wb(1'h1, ra(5, 1), 16'(p));
      wb(1'h1, ra(5, 2), 16'(32'h8000 | (c << 4)));
      gap(5, g);
      check(g, (p + 1) * divTab[c]);
    end
    wb(1'h1, ra(5, 2), 16'h0000);
    wb(1'h1, ra(5, 0), 16'h0000);
    wb(1'h1, ra(5, 1), 16'h0002);
    repeat (3) @(posedge sys_clk);
    g = evCnt[5];
    repeat (50) @(posedge sys_clk);
    check(evCnt[5] - g, 0);
    idleMode <= 1'h1;
    wb(1'h1, ra(5, 2), 16'hA000);
    g = evCnt[5];
    repeat (40) @(posedge sys_clk);
    check(evCnt[5] - g, 0);
    wb(1'h1, ra(5, 2), 16'h8000);
    g = evCnt[5];
    repeat (30) @(posedge sys_clk);
    check(32'(evCnt[5] - g > 5), 1);
    idleMode <= 1'h0;
    wb(1'h1, ra(5, 2), 16'h0000);
    $display("test prescale and idle done");
    // join first, run last; halt-in-idle clear keeps the pair going idle
    wb(1'h1, ra(1, 2), 16'h0008);
    wb(1'h1, ra(2, 2), 16'h8030);
    wb(1'h1, ra(1, 1), 16'h0002);
    wb(1'h1, ra(2, 1), 16'h0001);
    wb(1'h1, ra(1, 0), 16'hFFF0);
    wb(1'h1, ra(2, 0), 16'h0000);
    idleMode <= 1'h1;
    snap();
    wb(1'h1, ra(1, 2), 16'h8008);
    repeat (40) @(posedge sys_clk);
    check(evCnt[2] - b[1], 1);
    check(evCnt[1] - b[0], 0);
    check(adcCnt[0] - b[2], 1);
    check(dmaCnt[1] - b[3], 1);
    idleMode <= 1'h0;
    wb(1'h1, ra(1, 2), 16'h0000);
    wb(1'h1, ra(2, 2), 16'h0000);
    v1 = 16'($urandom);
    v2 = 16'($urandom);
    wb(1'h1, ra(1, 0), v1);
    wb(1'h1, ra(2, 0), v2);
    repeat (2) @(posedge sys_clk);
    check({16'h0000, capLow}, {16'h0000, v1});
    check({16'h0000, capHigh}, {16'h0000, v2});
    $display("test pair done");
    wb(1'h1, ra(4, 1), 16'h0001);
    wb(1'h1, ra(4, 2), 16'h8002);
    g = evCnt[4];
    b[0] = adcCnt[1];
    i_pins.burst(4, 6, 4);
    repeat (10) @(posedge sys_clk);
    check(evCnt[4] - g, 3);
    check(adcCnt[1] - b[0], 3);
    wb(1'h1, ra(0, 1), 16'h0001);
    for (int s = 0; s < 2; s++) begin
      wb(1'h1, ra(0, 0), 16'h0000);
      wb(1'h1, ra(0, 2), 16'(32'h8002 | (s << 2)));
      g = evCnt[0];
      i_pins.burst(0, 4, 2 + 2 * s);
      repeat (10) @(posedge sys_clk);
      check(evCnt[0] - g, 2);
    end
    wb(1'h1, ra(0, 1), 16'hFFFF);
    for (int s = 0; s < 2; s++) begin
      wb(1'h1, ra(0, 0), 16'h0000);
      wb(1'h1, ra(0, 2), 16'(32'h8040 | (s << 1)));
      g = evCnt[0];
      i_pins.level(0, 1'h1);
      repeat (20) @(posedge sys_clk);
      i_pins.level(0, 1'h0);
      repeat (10) @(posedge sys_clk);
      check(evCnt[0] - g, 1 - s);
      wb(1'h0, ra(0, 0), 16'h0000);
      check(rdat, 32'(21 - 20 * s));
    end
    wb(1'h0, 8'h90, 16'h0000);
    check(rdat, 32'h0000_0035);
    wb(1'h1, 8'h90, 16'h01FF);
    wb(1'h0, 8'h90, 16'h0000);
    check(rdat, 32'h0000_0000);
    $display("test pins done");
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
